/* hdl/tseu_core.sv */
// Trap entry sequencer with its trap stacks and register slave
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Updates follow order: level, save, type, globals, state, hyper, window, vector.
// - Each trap goes to supervisor or hypervisor by type, level, mode.
// - Normal trap raises trap_level by one; level five goes elsewhere.
// - New frame saves globals, flags, state, window, counters, hyper, type.
// - Global set level rises, capped by supervisor or hypervisor maximum.
// - Normal trap sets fpu enable, clears mask, interrupts and branch trap.
// - Supervisor sets privilege, copies trap endian; hypervisor clears both.
// - Hypervisor trap clears recovery, sets hyper mode, clears breakpoints.
// - Window traps move window pointer by type range.
// - Supervisor vector uses supervisor base, level bit, type, fixed tail.
// - Supervisor trap beyond supervisor depth vectors to hyper offset 040.
// - Hypervisor vector uses hyper base, type and fixed tail.
// - Interrupts ignored while interrupt enable is clear.
// - Frame n changes by hardware only on trap from level n-1.
// - Level five traps and traps in recovery use recovery path.
// - Recovery path trap raises level by one and saves same fields.
// - Recovery path caps global set level at hypervisor maximum.
// - Recovery path clears memory model, privilege, endian; sets fpu.
// - Recovery path sets recovery and hyper mode, clears breakpoints.
// - Recovery path adjusts window pointer like normal path.
// - Recovery path vector is recovery base with low byte A0.
// - Trap at deepest level pushes nothing and enters fatal stall.
// - Recovery state persists until software clears it or a trap at the deepest level enters fatal stall.
module tseu_core
    import tseu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trap_req,
    input wire logic [8:0] trap_type,
    input wire logic trap_is_intr,
    input wire logic trap_hyper_class,
    input wire logic [63:0] cur_pc,
    input wire logic [63:0] cur_npc,
    input wire logic [7:0] cur_ccr,
    input wire logic [7:0] cur_asi,
    input wire logic [2:0] saveable_windows,
    output logic trap_ready,
    output logic trap_taken,
    output logic trap_refused,
    output logic [63:0] handler_pc,
    output logic [63:0] handler_npc,
    output logic [2:0] trap_level,
    output logic [1:0] alt_reg_set_level,
    output logic [2:0] window_pointer,
    output logic [12:0] processor_state_reg,
    output logic [3:0] hyper_state_reg,
    output logic recovery_state,
    output logic fatal_stall_state
);
    tseu_state_type state, next_state;
    logic [2:0] next_tl, tl_inc;
    logic [1:0] next_gl, gl_lim;
    logic [2:0] next_cwp;
    logic [12:0] next_ps;
    logic [3:0] next_hp;
    logic [63:0] next_pc, next_npc;
    logic [63:0] supervisor_vector_base, hypervisor_vector_base, rstv, next_tba, next_hypervisor_vector_base, next_rstv;
    logic next_taken, next_refused;
    logic accept, recov, dhyp, gw, stk_we, tt_sw_we;
    logic wr_ok, rd_ok;
    logic [31:0] wmask, next_rdata;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid;
    logic [TS_W-1:0] ts_in;
    logic [63:0] spc, snpc;
    // Stacks have no reset: a frame is only meaningful once pushed
    logic [TS_W-1:0] saved_state_stack [1:MAX_TL];
    logic [3:0] saved_hyper_state_stack [1:MAX_TL];
    logic [63:0] saved_pc_stack [1:MAX_TL];
    logic [63:0] saved_next_pc_stack [1:MAX_TL];
    logic [8:0] trap_type_stack [1:MAX_TL];

    // ==========================================================
    // Trap acceptance
    assign trap_ready = (state != ST_STALL);
    assign accept = trap_req && trap_ready
        && !(trap_is_intr && !processor_state_reg[PS_IE]);
    assign tl_inc = trap_level + 3'h1;
    assign recov = (state == ST_RECOV) || (trap_level == MAX_TL_M1);
    // Guest watchdog: supervisor trap too deep for supervisor handling
    assign gw = !recov && !hyper_state_reg[HP_HPRIV]
        && !trap_hyper_class && (tl_inc > MAX_PTL);
    assign dhyp = recov || hyper_state_reg[HP_HPRIV]
        || trap_hyper_class || gw;
    assign spc = processor_state_reg[PS_AM] ?
        {AM_HIGH, cur_pc[31:0]} : cur_pc;
    assign snpc = processor_state_reg[PS_AM] ?
        {AM_HIGH, cur_npc[31:0]} : cur_npc;
    assign ts_in = {alt_reg_set_level, cur_ccr, cur_asi,
        processor_state_reg, window_pointer};
    assign recovery_state = (state == ST_RECOV);
    assign fatal_stall_state = (state == ST_STALL);

    // ==========================================================
    // Register bus handshake
    assign wr_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_ok;
    assign s_axi_wready = wr_ok;
    assign rd_ok = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // ==========================================================
    // Next processor state; software first so a trap overrides the fields it sets
    always_comb
    begin
        logic [31:0] w;
        w = 32'h0000_0000;
        next_state = state;
        next_tl = trap_level;
        next_gl = alt_reg_set_level;
        next_cwp = window_pointer;
        next_ps = processor_state_reg;
        next_hp = hyper_state_reg;
        next_pc = handler_pc;
        next_npc = handler_npc;
        next_tba = supervisor_vector_base;
        next_hypervisor_vector_base = hypervisor_vector_base;
        next_rstv = rstv;
        next_taken = 1'b0;
        next_refused = 1'b0;
        stk_we = 1'b0;
        tt_sw_we = 1'b0;
        gl_lim = dhyp ? MAX_GL : MAX_PGL;
        if (wr_ok)
        begin
            unique case (s_axi_awaddr)
                REG_CTRL:
                begin
                    w = merge({8'h00, 4'h0, hyper_state_reg, 5'h00,
                        window_pointer, 2'h0, alt_reg_set_level, 1'b0,
                        trap_level}, s_axi_wdata, wmask);
                    next_tl = w[TL_W-1:0];
                    next_gl = w[CT_GL +: GL_W];
                    next_cwp = w[CT_CWP +: CWP_W];
                    next_hp = w[CT_HP +: HP_W];
                    // Leaving recovery for run only by software; stall needs reset
                    if (state != ST_STALL)
                    begin
                        next_state = w[CT_HP + HP_RED] ?
                            ST_RECOV : ST_RUN;
                    end
                end
                REG_PSTATE:
                begin
                    w = merge({19'h0_0000, processor_state_reg},
                        s_axi_wdata, wmask);
                    next_ps = w[PS_W-1:0];
                end
                REG_TBA_LO: next_tba[31:0] = merge(supervisor_vector_base[31:0],
                    s_axi_wdata, wmask);
                REG_TBA_HI: next_tba[63:32] = merge(supervisor_vector_base[63:32],
                    s_axi_wdata, wmask);
                REG_HYPERVISOR_VECTOR_BASE_LO: next_hypervisor_vector_base[31:0] = merge(hypervisor_vector_base[31:0],
                    s_axi_wdata, wmask);
                REG_HYPERVISOR_VECTOR_BASE_HI: next_hypervisor_vector_base[63:32] = merge(hypervisor_vector_base[63:32],
                    s_axi_wdata, wmask);
                REG_RSTV_LO: next_rstv[31:0] = merge(rstv[31:0],
                    s_axi_wdata, wmask);
                REG_RSTV_HI: next_rstv[63:32] = merge(rstv[63:32],
                    s_axi_wdata, wmask);
                REG_TT: tt_sw_we = (trap_level != 3'h0);
                default: w = 32'h0000_0000;
            endcase
        end
        if (accept && trap_level == MAX_TL)
        begin
            // A trap wins over a control-word write in the same cycle; a PSTATE write still lands
            next_tl = trap_level;
            next_gl = alt_reg_set_level;
            next_cwp = window_pointer;
            next_hp = hyper_state_reg;
            next_state = ST_STALL;
        end
        else if (accept)
        begin
            next_cwp = window_pointer;
            next_hp = hyper_state_reg;
            next_ps = processor_state_reg;
            next_taken = 1'b1;
            next_tl = tl_inc;
            stk_we = 1'b1;
            next_gl = (alt_reg_set_level < gl_lim) ?
                alt_reg_set_level + 2'h1 : gl_lim;
            next_ps[PS_PEF] = 1'b1;
            next_ps[PS_AM] = 1'b0;
            next_ps[PS_IE] = 1'b0;
            next_ps[PS_TCT] = 1'b0;
            next_ps[PS_PRIV] = !dhyp;
            next_ps[PS_CLE] = dhyp ? 1'b0 : processor_state_reg[PS_TLE];
            if (recov)
            begin
                next_ps[PS_MM +: 2] = 2'h0;
                next_hp = 4'h0;
                next_hp[HP_RED] = 1'b1;
                next_hp[HP_HPRIV] = 1'b1;
                next_state = ST_RECOV;
            end
            else if (dhyp)
            begin
                next_hp[HP_RED] = 1'b0;
                next_hp[HP_HPRIV] = 1'b1;
                next_hp[HP_IBE] = 1'b0;
            end
            if (trap_type == TT_CLEAN)
                next_cwp = window_pointer + 3'h1;
            else if (trap_type >= TT_SPILL_LO && trap_type <= TT_SPILL_HI)
                next_cwp = window_pointer + saveable_windows + 3'h2;
            else if (trap_type >= TT_FILL_LO && trap_type <= TT_FILL_HI)
                next_cwp = window_pointer - 3'h1;
            if (recov)
            begin
                next_pc = {rstv[63:8], RV_PC};
                next_npc = {rstv[63:8], RV_NPC};
            end
            else if (gw)
            begin
                next_pc = {hypervisor_vector_base[63:14], 2'h0, GW_PC};
                next_npc = {hypervisor_vector_base[63:14], 2'h0, GW_NPC};
            end
            else if (dhyp)
            begin
                next_pc = {hypervisor_vector_base[63:14], trap_type, PC_TAIL};
                next_npc = {hypervisor_vector_base[63:14], trap_type, NPC_TAIL};
            end
            else
            begin
                next_pc = {supervisor_vector_base[63:15], tl_inc > 3'h1, trap_type,
                    PC_TAIL};
                next_npc = {supervisor_vector_base[63:15], tl_inc > 3'h1, trap_type,
                    NPC_TAIL};
            end
        end
        else if (trap_req && trap_ready)
        begin
            next_refused = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_RUN;
            trap_level <= 3'h0;
            alt_reg_set_level <= 2'h0;
            window_pointer <= 3'h0;
            processor_state_reg <= 13'h0000;
            hyper_state_reg <= 4'h0;
            handler_pc <= 64'h0000_0000_0000_0000;
            handler_npc <= 64'h0000_0000_0000_0000;
            supervisor_vector_base <= 64'h0000_0000_0000_0000;
            hypervisor_vector_base <= 64'h0000_0000_0000_0000;
            rstv <= 64'h0000_0000_0000_0000;
            trap_taken <= 1'b0;
            trap_refused <= 1'b0;
        end
        else
        begin
            state <= next_state;
            trap_level <= next_tl;
            alt_reg_set_level <= next_gl;
            window_pointer <= next_cwp;
            processor_state_reg <= next_ps;
            hyper_state_reg <= next_hp;
            handler_pc <= next_pc;
            handler_npc <= next_npc;
            supervisor_vector_base <= next_tba;
            hypervisor_vector_base <= next_hypervisor_vector_base;
            rstv <= next_rstv;
            trap_taken <= next_taken;
            trap_refused <= next_refused;
        end
    end

    // ==========================================================
    // Trap stacks
    always_ff @(posedge aclk)
    begin
        if (stk_we)
        begin
            saved_state_stack[tl_inc] <= ts_in;
            saved_hyper_state_stack[tl_inc] <= hyper_state_reg;
            saved_pc_stack[tl_inc] <= spc;
            saved_next_pc_stack[tl_inc] <= snpc;
            trap_type_stack[tl_inc] <= trap_type;
        end
        else if (tt_sw_we)
        begin
            trap_type_stack[trap_level] <= s_axi_wdata[TT_W-1:0];
        end
    end

    // ==========================================================
    // Register bus responses
    always_comb
    begin
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (wr_ok)
        begin
            next_bvalid = 1'b1;
            next_bresp = (s_axi_awaddr <= REG_TT) ? RESP_OKAY : RESP_DECERR;
        end
        if (rd_ok)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                REG_CTRL: next_rdata = {7'h00, fatal_stall_state, 4'h0,
                    hyper_state_reg, 5'h00, window_pointer, 2'h0,
                    alt_reg_set_level, 1'b0, trap_level};
                REG_PSTATE: next_rdata = {19'h0_0000, processor_state_reg};
                REG_TBA_LO: next_rdata = supervisor_vector_base[31:0];
                REG_TBA_HI: next_rdata = supervisor_vector_base[63:32];
                REG_HYPERVISOR_VECTOR_BASE_LO: next_rdata = hypervisor_vector_base[31:0];
                REG_HYPERVISOR_VECTOR_BASE_HI: next_rdata = hypervisor_vector_base[63:32];
                REG_RSTV_LO: next_rdata = rstv[31:0];
                REG_RSTV_HI: next_rdata = rstv[63:32];
                REG_TT, REG_TPC_LO, REG_TPC_HI, REG_TS_LO, REG_TS_HI,
                REG_SAVED_NEXT_PC_STACK_LO, REG_SAVED_NEXT_PC_STACK_HI:
                begin
                    // Level zero has no frame; it reads as zero
                    if (trap_level != 3'h0)
                    begin
                        unique case (s_axi_araddr)
                            REG_TT: next_rdata = {23'h00_0000,
                                trap_type_stack[trap_level]};
                            REG_TPC_LO: next_rdata =
                                saved_pc_stack[trap_level][31:0];
                            REG_TPC_HI: next_rdata =
                                saved_pc_stack[trap_level][63:32];
                            REG_TS_LO: next_rdata =
                                saved_state_stack[trap_level][31:0];
                            REG_TS_HI: next_rdata = {26'h000_0000,
                                saved_hyper_state_stack[trap_level],
                                saved_state_stack[trap_level][33:32]};
                            REG_SAVED_NEXT_PC_STACK_LO: next_rdata =
                                saved_next_pc_stack[trap_level][31:0];
                            default: next_rdata =
                                saved_next_pc_stack[trap_level][63:32];
                        endcase
                    end
                end
                default: next_rresp = RESP_DECERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end
        else
        begin
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    property p_tl_inc;
        @(posedge aclk) disable iff (!aresetn)
        accept && trap_level < MAX_TL_M1 |=>
            trap_level == $past(trap_level) + 3'h1 && trap_taken;
    endproperty
    a_tl_inc: assert property (p_tl_inc)
        else $error("Trap level did not advance by one");

    property p_stall;
        @(posedge aclk) disable iff (!aresetn)
        accept && trap_level == MAX_TL |=>
            fatal_stall_state && !trap_taken && trap_level == MAX_TL;
    endproperty
    a_stall: assert property (p_stall)
        else $error("Deepest level trap did not stall");

    property p_ps_forced;
        @(posedge aclk) disable iff (!aresetn)
        trap_taken |-> processor_state_reg[PS_PEF]
            && !processor_state_reg[PS_AM] && !processor_state_reg[PS_IE]
            && !processor_state_reg[PS_TCT];
    endproperty
    a_ps_forced: assert property (p_ps_forced)
        else $error("Processor state not forced on trap");

    property p_intr_mask;
        @(posedge aclk) disable iff (!aresetn)
        trap_req && trap_is_intr && !processor_state_reg[PS_IE]
            |=> !trap_taken;
    endproperty
    a_intr_mask: assert property (p_intr_mask)
        else $error("Masked interrupt was taken");

    property p_recov_vec;
        @(posedge aclk) disable iff (!aresetn)
        accept && $past(1'b1) && trap_level == MAX_TL_M1 |=>
            handler_pc == {rstv[63:8], RV_PC} && trap_level == MAX_TL
            && hyper_state_reg[HP_RED] && hyper_state_reg[HP_HPRIV]
            && !hyper_state_reg[HP_IBE] && !hyper_state_reg[HP_TLZ];
    endproperty
    a_recov_vec: assert property (p_recov_vec)
        else $error("Recovery trap vector or hyper state wrong");

    property p_gl_inc;
        @(posedge aclk) disable iff (!aresetn)
        accept && trap_level != MAX_TL && alt_reg_set_level < MAX_PGL
            |=> alt_reg_set_level == $past(alt_reg_set_level) + 2'h1;
    endproperty
    a_gl_inc: assert property (p_gl_inc)
        else $error("Global set level did not increment");

    property p_tt_saved;
        @(posedge aclk) disable iff (!aresetn)
        trap_taken |-> trap_type_stack[trap_level] == $past(trap_type)
            && saved_pc_stack[trap_level] == $past(spc);
    endproperty
    a_tt_saved: assert property (p_tt_saved)
        else $error("Frame not saved at new level");

    property p_stay_recov;
        @(posedge aclk) disable iff (!aresetn)
        recovery_state && !(wr_ok && s_axi_awaddr == REG_CTRL)
            |=> recovery_state || fatal_stall_state;
    endproperty
    a_stay_recov: assert property (p_stay_recov)
        else $error("Recovery state left without software");
endmodule

/* hdl/tseu_pkg.sv */
// Constants, field layout and register map of the trap entry sequencer
package tseu_pkg;
    localparam int TL_W = 3;
    localparam logic [2:0] MAX_TL = 3'h6;
    localparam logic [2:0] MAX_TL_M1 = 3'h5;
    localparam logic [2:0] MAX_PTL = 3'h2;
    localparam int GL_W = 2;
    localparam logic [1:0] MAX_GL = 2'h3;
    localparam logic [1:0] MAX_PGL = 2'h2;
    localparam int CWP_W = 3;
    localparam int TT_W = 9;
    localparam int PS_W = 13;
    localparam int HP_W = 4;
    localparam int TS_W = GL_W + 16 + PS_W + CWP_W;
    // Processor state field positions
    localparam int PS_IE = 1;
    localparam int PS_PRIV = 2;
    localparam int PS_AM = 3;
    localparam int PS_PEF = 4;
    localparam int PS_MM = 6;
    localparam int PS_TLE = 8;
    localparam int PS_CLE = 9;
    localparam int PS_TCT = 12;
    // Hyper state field positions
    localparam int HP_TLZ = 0;
    localparam int HP_IBE = 1;
    localparam int HP_HPRIV = 2;
    localparam int HP_RED = 3;
    // Window trap types
    localparam logic [8:0] TT_CLEAN = 9'h024;
    localparam logic [8:0] TT_SPILL_LO = 9'h080;
    localparam logic [8:0] TT_SPILL_HI = 9'h0bf;
    localparam logic [8:0] TT_FILL_LO = 9'h0c0;
    localparam logic [8:0] TT_FILL_HI = 9'h0ff;
    // Vector tails
    localparam logic [4:0] PC_TAIL = 5'h00;
    localparam logic [4:0] NPC_TAIL = 5'h04;
    localparam logic [11:0] GW_PC = 12'h040;
    localparam logic [11:0] GW_NPC = 12'h044;
    localparam logic [7:0] RV_PC = 8'ha0;
    localparam logic [7:0] RV_NPC = 8'ha4;
    localparam logic [31:0] AM_HIGH = 32'h0000_0000;
    // Register map, byte addresses
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_PSTATE = 12'h004;
    localparam logic [11:0] REG_TBA_LO = 12'h008;
    localparam logic [11:0] REG_TBA_HI = 12'h00c;
    localparam logic [11:0] REG_HYPERVISOR_VECTOR_BASE_LO = 12'h010;
    localparam logic [11:0] REG_HYPERVISOR_VECTOR_BASE_HI = 12'h014;
    localparam logic [11:0] REG_RSTV_LO = 12'h018;
    localparam logic [11:0] REG_RSTV_HI = 12'h01c;
    localparam logic [11:0] REG_TT = 12'h020;
    localparam logic [11:0] REG_TPC_LO = 12'h024;
    localparam logic [11:0] REG_TPC_HI = 12'h028;
    localparam logic [11:0] REG_TS_LO = 12'h02c;
    localparam logic [11:0] REG_TS_HI = 12'h030;
    localparam logic [11:0] REG_SAVED_NEXT_PC_STACK_LO = 12'h034;
    localparam logic [11:0] REG_SAVED_NEXT_PC_STACK_HI = 12'h038;
    // Control word field positions
    localparam int CT_GL = 4;
    localparam int CT_CWP = 8;
    localparam int CT_HP = 16;
    localparam int CT_STALL = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_RECOV = 3'b010,
        ST_STALL = 3'b100
    } tseu_state_type;
endpackage

/* tb/trap_entry_state_update_tb.sv */
// Self-checking bench for the trap entry sequencer
`timescale 1ns/1ps
module trap_entry_state_update_tb;
    import tseu_pkg::*;
    localparam logic [63:0] SUPERVISOR_VECTOR_BASE = 64'h0000_00ab_1234_8000;
    localparam logic [63:0] HYPERVISOR_VECTOR_BASE = 64'h0000_00cd_0001_4000;
    localparam logic [63:0] RSTV = 64'h0000_00ef_5555_5555;
    logic aclk = 0, aresetn = 0, fire = 0, trap_hyper_class = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb = '0, hyper_state_reg;
    logic [1:0] s_axi_bresp, s_axi_rresp, alt_reg_set_level;
    logic [9:0] req = '0;
    logic [8:0] trap_type;
    logic [63:0] cur_pc, cur_npc, handler_pc, handler_npc;
    logic [7:0] cur_ccr = 8'h5a, cur_asi = 8'h80;
    logic [2:0] saveable_windows = 3'h2, trap_level, window_pointer;
    logic [12:0] processor_state_reg;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, trap_req, trap_is_intr, trap_ready, trap_taken;
    logic trap_refused, recovery_state, fatal_stall_state;
    int bad_count = 0, n_checks = 0;
    assign cur_npc = cur_pc + 64'h0000_0000_0000_0004;
    tseu_trap_src tseu_trap_src_inst (.*);
    tseu_core tseu_core_inst (.*);
    always #10 aclk = ~aclk;
    task automatic chk(input string nm, input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge aclk); while (!s_axi_awready);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", s_axi_bresp, a <= REG_TT ? RESP_OKAY : RESP_DECERR);
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        chk("rresp", s_axi_rresp, a > REG_SAVED_NEXT_PC_STACK_HI ? RESP_DECERR : RESP_OKAY);
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask
    task automatic trap(input logic [9:0] r, input logic h);
        {fire, req, trap_hyper_class} <= {1'b1, r, h};
        @(posedge aclk);
        fire <= 0;
        do @(posedge aclk);
        while (!(trap_taken || trap_refused || fatal_stall_state));
    endtask
    task automatic t_super;
        wr(REG_TBA_LO, SUPERVISOR_VECTOR_BASE[31:0]);
        wr(REG_TBA_HI, SUPERVISOR_VECTOR_BASE[63:32]);
        wr(REG_PSTATE, 32'h0000_018a);
        trap(10'h024, 1'b0);
        chk("tl", trap_level, 3'h1);
        chk("gl", alt_reg_set_level, 2'h1);
        chk("wp", window_pointer, 3'h1);
        chk("ps", processor_state_reg, 13'h0394);
        chk("hs", hyper_state_reg, 4'h0);
        chk("pc", handler_pc, {SUPERVISOR_VECTOR_BASE[63:15], 1'b0, 9'h024, 5'h00});
        chk("npc", handler_npc, {SUPERVISOR_VECTOR_BASE[63:15], 1'b0, 9'h024, 5'h04});
        rd(REG_TPC_HI);
        chk("tpc", rd_d, 32'h0000_0000);
        rd(REG_TS_LO);
        chk("ts", rd_d, 32'h5a80_0c50);
        rd(REG_TT);
        chk("tt", rd_d, 32'h0000_0024);
        wr(REG_TT, 32'h0000_0077);
        rd(REG_TT);
        chk("ttw", rd_d, 32'h0000_0077);
        $display("%m done");
    endtask
    task automatic t_hyper;
        wr(REG_HYPERVISOR_VECTOR_BASE_LO, HYPERVISOR_VECTOR_BASE[31:0]);
        wr(REG_HYPERVISOR_VECTOR_BASE_HI, HYPERVISOR_VECTOR_BASE[63:32]);
        trap(10'h085, 1'b1);
        chk("tl", trap_level, 3'h2);
        chk("gl", alt_reg_set_level, 2'h2);
        chk("wp", window_pointer, 3'h5);
        chk("ps", processor_state_reg, 13'h0190);
        chk("hs", hyper_state_reg, 4'h4);
        chk("pc", handler_pc, {HYPERVISOR_VECTOR_BASE[63:14], 9'h085, 5'h00});
        trap(10'h241, 1'b0);
        chk("ref", trap_refused, 1'b1);
        chk("tl", trap_level, 3'h2);
        rd(12'h040);
        chk("dec", rd_d, 32'h0000_0000);
        $display("%m done");
    endtask
    task automatic t_recov;
        wr(REG_CTRL, 32'h0000_0102);
        trap(10'h011, 1'b0);
        chk("pc", handler_pc, {HYPERVISOR_VECTOR_BASE[63:14], 2'b00, 12'h040});
        chk("npc", handler_npc, {HYPERVISOR_VECTOR_BASE[63:14], 2'b00, 12'h044});
        wr(REG_RSTV_LO, RSTV[31:0]);
        wr(REG_RSTV_HI, RSTV[63:32]);
        trap(10'h011, 1'b0);
        trap(10'h011, 1'b0);
        trap(10'h0c3, 1'b0);
        chk("tl", trap_level, 3'h6);
        chk("red", recovery_state, 1'b1);
        chk("gl", alt_reg_set_level, 2'h3);
        chk("wp", window_pointer, 3'h0);
        chk("ps", processor_state_reg, 13'h0110);
        chk("hs", hyper_state_reg, 4'hc);
        chk("pc", handler_pc, {RSTV[63:8], 8'ha0});
        chk("npc", handler_npc, {RSTV[63:8], 8'ha4});
        trap(10'h011, 1'b0);
        chk("fs", fatal_stall_state, 1'b1);
        chk("tl", trap_level, 3'h6);
        chk("rdy", trap_ready, 1'b0);
        $display("%m done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk("rst", {trap_level, processor_state_reg}, 16'h0000);
        t_super;
        t_hyper;
        t_recov;
        finish_test;
    end
    // Whole run is well under a thousand cycles
    initial
    begin
        #50us;
        bad_count++;
        finish_test;
    end
endmodule

/* tb/tseu_trap_src.sv */
// Exception source model that raises trap requests for the sequencer
`timescale 1ns/1ps
module tseu_trap_src
(
    input wire logic aclk,
    input wire logic fire,
    input wire logic [9:0] req,
    output logic trap_req,
    output logic [8:0] trap_type,
    output logic trap_is_intr,
    output logic [63:0] cur_pc
);
    // Type lines invert outside a request so stale values never pass
    always @(posedge aclk)
    begin
        trap_req <= fire;
        trap_type <= fire ? req[8:0] : ~req[8:0];
        trap_is_intr <= fire ? req[9] : ~req[9];
        cur_pc <= {32'hffff_0000, 23'h00_0000, req[8:0]};
    end
endmodule
